// [shared/gpf_defines.svh]
/*
 * Register offsets, reset values and field layouts of the eight pin port.
 * Assumes byte addresses on a 32-bit APB; included by bare name.
 */
// What this block does
// RULE_01: Data bit 0 is low, 1 high
// RULE_02: Direction bit 0 output, 1 input
// RULE_03: Direction register eight bits, resets zero
// RULE_04: Output codes: hiz, p-drain, n-drain, push-pull
// RULE_05: Input codes: hiz, pull-down, pull-up, hiz
// RULE_06: Pin n code bits at bit n
// RULE_07: Control registers byte or word access, reset zero
// RULE_08: Reset gives high-impedance outputs everywhere
// RULE_09: Output pins present their data bit
// RULE_10: Input pins read back sampled level
// RULE_11: Every pin configured independently
// RULE_12: Segment select yields the pin
// RULE_13: Output pins read back written value
// RULE_14: Open drains drive only one level
`ifndef GPF_DEFINES_SVH
`define GPF_DEFINES_SVH

// Byte addresses of the registers
`define GPF_ADDR_LEVEL     16'hF278
`define GPF_ADDR_DIR       16'hF279
`define GPF_ADDR_SEL_LO    16'hF27A
`define GPF_ADDR_SEL_HI    16'hF27B

// Reset values
`define GPF_RST_LEVEL      8'h00
`define GPF_RST_DIR        8'h00
`define GPF_RST_SEL        8'h00

// Field layout within a 32-bit data word
`define GPF_BYTE_LSB       0
`define GPF_BYTE_MSB       7
`define GPF_HI_LSB         8
`define GPF_HI_MSB         15

`endif

// [shared/gpf_pkg.sv]
/*
 * Types of the eight pin port.
 * Assumes gpf_defines.svh supplies the numbers.
 */
package gpf_pkg;
    // Per-pin drive code as stored in the two control registers
    typedef enum logic [1:0] {
        GPF_CODE_HIZ  = 2'b00,
        GPF_CODE_PCH  = 2'b01,
        GPF_CODE_NCH  = 2'b10,
        GPF_CODE_CMOS = 2'b11
    } gpf_code_e;

    // Register byte selected by an access
    typedef enum logic [2:0] {
        GPF_REG_NONE  = 3'b000,
        GPF_REG_LEVEL = 3'b001,
        GPF_REG_DIR   = 3'b010,
        GPF_REG_SELLO = 3'b011,
        GPF_REG_SELHI = 3'b100
    } gpf_reg_e;

    // All state of the top module
    typedef struct packed {
        logic [7:0] level;
        logic [7:0] dir;
        logic [7:0] sel_lo;
        logic [7:0] sel_hi;
        logic [7:0] pin_smp;
        logic [31:0] prdata;
    } gpf_state_s;
endpackage

// [rtl/gpf_pin.sv]
/*
 * Driver and pull logic of one port pin, purely combinational.
 * Assumes the pad follows oe/out/pull signals from this cell.
 */
`timescale 1ns/1ps
module gpf_pin
    import gpf_pkg::*;
(
    input wire logic dir_i,        // 0 output, 1 input
    input wire logic [1:0] code_i, // Drive or input style
    input wire logic level_i,      // Written data bit
    input wire logic seg_i,        // Segment driver owns the pin
    output logic out_o,            // Level driven when enabled
    output logic oe_o,             // High while driving
    output logic pu_o,             // Pull-up enable
    output logic pd_o              // Pull-down enable
);
    // Decode one pin; no other pin is looked at
    always_comb begin
        out_o = level_i;                               // [RULE_01]
        oe_o = 1'b0;
        pu_o = 1'b0;
        pd_o = 1'b0;
        if (seg_i) begin
            // Yield the pad entirely to the display driver
            out_o = 1'b0;                              // [RULE_12]
        end else if (!dir_i) begin                     // [RULE_02]
            case (gpf_code_e'(code_i))                 // [RULE_04]
                GPF_CODE_PCH: begin
                    oe_o = level_i;                    // [RULE_14]
                end
                GPF_CODE_NCH: begin
                    oe_o = ~level_i;                   // [RULE_14]
                end
                GPF_CODE_CMOS: begin
                    oe_o = 1'b1;                       // [RULE_09]
                end
                default: begin
                    oe_o = 1'b0;                       // [RULE_08]
                end
            endcase
        end else begin
            // Input styles; codes 00 and 11 both float
            case (gpf_code_e'(code_i))                 // [RULE_05]
                GPF_CODE_PCH: begin
                    pd_o = 1'b1;
                end
                GPF_CODE_NCH: begin
                    pu_o = 1'b1;
                end
                default: begin
                    pd_o = 1'b0;
                end
            endcase
        end
    end
endmodule

// [rtl/gpf_port.sv]
/*
 * Eight pin general-purpose port with APB register access.
 * Assumes pin inputs synchronous to clk_sys_i and an APB master.
 */
`timescale 1ns/1ps
`include "gpf_defines.svh"
module gpf_port
    import gpf_pkg::*;
#(
    parameter int NPINS = 8 // Port width
)(
    input wire logic clk_sys_i,              // 40 MHz system clock
    input wire logic rstn_i,                 // Async reset, active low
    input wire logic clk_en_i,               // Freezes state when low
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [NPINS-1:0] seg_select_i, // Segment owns pin
    input wire logic [NPINS-1:0] pin_in_i,     // Pad levels
    output logic [NPINS-1:0] pin_out_o,        // Driven levels
    output logic [NPINS-1:0] pin_oe_o,         // High while driving
    output logic [NPINS-1:0] pin_pu_o,         // Pull-up enables
    output logic [NPINS-1:0] pin_pd_o          // Pull-down enables
);
    gpf_state_s st_q; // All registered state
    gpf_state_s st_d; // Next state
    gpf_reg_e reg_sel; // Decoded register
    logic wide_sel; // Word access to the control pair
    logic setup; // APB setup phase
    logic wr_en; // Write commits in this cycle
    logic [7:0] level_rd; // Per-bit mux of data readback

    // Address decode; word access at the pair base covers both
    always_comb begin
        wide_sel = 1'b0;
        if (paddr_i == `GPF_ADDR_LEVEL) begin
            reg_sel = GPF_REG_LEVEL;
        end else if (paddr_i == `GPF_ADDR_DIR) begin
            reg_sel = GPF_REG_DIR;                      // [RULE_03]
        end else if (paddr_i == `GPF_ADDR_SEL_LO) begin
            reg_sel = GPF_REG_SELLO;                    // [RULE_07]
            wide_sel = pstrb_i[1] || !pwrite_i;
        end else if (paddr_i == `GPF_ADDR_SEL_HI) begin
            reg_sel = GPF_REG_SELHI;
        end else begin
            reg_sel = GPF_REG_NONE;
        end
    end

    // Read level per pin: written value or sampled pad
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_rd[i] = st_q.dir[i] ? st_q.pin_smp[i]  // [RULE_10]
                                      : st_q.level[i];   // [RULE_13]
        end
    end

    // Single-cycle access phase; slave never waits
    assign setup = psel_i && !penable_i;
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && (reg_sel == GPF_REG_NONE);
    assign prdata_o = st_q.prdata;

    // Next-state logic for registers, pad samples and read data
    always_comb begin
        st_d = st_q;
        st_d.pin_smp = pin_in_i[7:0];
        if (wr_en && pstrb_i[0]) begin
            if (reg_sel == GPF_REG_LEVEL) begin
                st_d.level = pwdata_i[`GPF_BYTE_MSB:`GPF_BYTE_LSB];
            end else if (reg_sel == GPF_REG_DIR) begin
                st_d.dir = pwdata_i[`GPF_BYTE_MSB:`GPF_BYTE_LSB];
            end else if (reg_sel == GPF_REG_SELLO) begin
                st_d.sel_lo = pwdata_i[`GPF_BYTE_MSB:`GPF_BYTE_LSB];
            end else if (reg_sel == GPF_REG_SELHI) begin
                st_d.sel_hi = pwdata_i[`GPF_BYTE_MSB:`GPF_BYTE_LSB];
            end
        end
        // Upper byte lane of a word write fills the high register
        if (wr_en && wide_sel && pstrb_i[1]) begin
            st_d.sel_hi = pwdata_i[`GPF_HI_MSB:`GPF_HI_LSB]; // [RULE_07]
        end
        // Read data captured in setup, stable through access
        if (setup && !pwrite_i) begin
            st_d.prdata = 32'h0000_0000;
            if (reg_sel == GPF_REG_LEVEL) begin
                st_d.prdata[7:0] = level_rd;
            end else if (reg_sel == GPF_REG_DIR) begin
                st_d.prdata[7:0] = st_q.dir;
            end else if (reg_sel == GPF_REG_SELLO) begin
                st_d.prdata[15:0] = {st_q.sel_hi, st_q.sel_lo};
            end else if (reg_sel == GPF_REG_SELHI) begin
                st_d.prdata[7:0] = st_q.sel_hi;
            end
        end
    end

    // State register; reset leaves every pin a floating output
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q.level <= `GPF_RST_LEVEL;
            st_q.dir <= `GPF_RST_DIR;                   // [RULE_02]
            st_q.sel_lo <= `GPF_RST_SEL;                // [RULE_08]
            st_q.sel_hi <= `GPF_RST_SEL;
            st_q.pin_smp <= 8'h00;
            st_q.prdata <= 32'h0000_0000;
        end else if (clk_en_i) begin
            st_q <= st_d;
        end
    end

    // One independent cell per pin
    for (genvar n = 0; n < NPINS; n++) begin : g_pin
        gpf_pin u_pin (
            .dir_i(st_q.dir[n]),                        // [RULE_11]
            .code_i({st_q.sel_hi[n], st_q.sel_lo[n]}),  // [RULE_06]
            .level_i(st_q.level[n]),                    // [RULE_09]
            .seg_i(seg_select_i[n]),
            .out_o(pin_out_o[n]),
            .oe_o(pin_oe_o[n]),
            .pu_o(pin_pu_o[n]),
            .pd_o(pin_pd_o[n])
        );
    end
endmodule

// [tb/gpf_checker.sv]
/* Assertions on the eight pin port's pins and APB answers.
   Bound to gpf_port from tb; sees only its ports. */
`timescale 1ns/1ps
`include "gpf_defines.svh"
module gpf_checker #(
    parameter int NPINS = 8 // Port width
)(
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [15:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [NPINS-1:0] seg_select_i,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic [NPINS-1:0] pin_pu_o,
    input wire logic [NPINS-1:0] pin_pd_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Access phase, and whether it hits one of the four bytes
    wire logic acc = psel_i && penable_i;
    wire logic hit = paddr_i >= `GPF_ADDR_LEVEL
        && paddr_i <= `GPF_ADDR_SEL_HI;
    // Any pin doing anything to the pad
    wire logic [NPINS-1:0] busy = pin_oe_o | pin_pu_o | pin_pd_o;
    a_ready_high: assert property (pready_o)
        else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr_o == !hit)
        else $error("pslverr wrong for address");
    a_unmapped_zero: assert property (psel_i && !penable_i && !pwrite_i
        && clk_en_i && !hit |=> prdata_o == 0)
        else $error("unmapped read not zero");
    a_freeze_rd: assert property (!clk_en_i |=> $stable(prdata_o))
        else $error("read data moved while frozen");
    a_seg_yields: assert property ((busy & seg_select_i) == 0)
        else $error("segment pin still used by port");
    a_pull_drive: assert property ((pin_oe_o & (pin_pu_o | pin_pd_o)) == 0)
        else $error("pull enabled on driven pin");
    a_pull_pair: assert property ((pin_pu_o & pin_pd_o) == 0)
        else $error("both pulls on");
    // Reset must quiet the pins even though reset disables the rest
    a_reset_quiet: assert property (disable iff (1'b0) !rstn_i |-> busy == 0)
        else $error("pin busy in reset");
    a_all_input: assert property (acc && pwrite_i && clk_en_i
        && pstrb_i[0] && paddr_i == `GPF_ADDR_DIR
        && pwdata_i[7:0] == 8'hff |=> pin_oe_o == 0)
        else $error("input pin still driven");
    c_word_ctrl: cover property (acc && pwrite_i && pstrb_i == 4'h3);
    c_unmapped: cover property (acc && !hit);
    c_pulled: cover property (|pin_pu_o && |pin_pd_o);
endmodule

// [tb/gpf_pad.sv]
/* Board model of the eight pads: resolves each pad level.
   Assumes the bench never drives a pin the port drives. */
`timescale 1ns/1ps
module gpf_pad (
    input wire logic [7:0] out_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pu_i,
    input wire logic [7:0] pd_i,
    input wire logic [7:0] ext_i,    // Board drive value
    input wire logic [7:0] ext_en_i, // Board drives pin
    output logic [7:0] lvl_o
);
    // Port driver first, then board, then pulls; a floating pad
    // shows the inverse of the board value so no stale level passes
    assign lvl_o = (oe_i & out_i) | (~oe_i & ((ext_en_i & ext_i)
        | (~ext_en_i & (pu_i | (~pd_i & ~ext_i)))));
endmodule

// [tb/tb.sv]
/* Self-checking bench of gpf_port with random pin setups.
   Assumes gpf_pad beside the port and gpf_checker bound in. */
`timescale 1ns/1ps
`include "gpf_defines.svh"
module tb;
    // Reset starts released so the first drive low is a real edge
    logic clk = 0, rstn = 1, en = 1, psel = 0, pen = 0, pw = 0;
    logic [15:0] pa = 0;
    logic [31:0] pd = 0, rs = 1, q, e, rd;
    logic [3:0] ps = 0;
    logic [7:0] seg = 0, ext = 0, een = 0;
    wire logic [31:0] prd;
    wire logic prdy, perr;
    wire logic [7:0] po, poe, ppu, ppd, pin;
    int n_mismatch = 0, compares = 0, cyc = 0;
    always #12.5 clk = ~clk;
    gpf_port #(.NPINS(8)) DUT (.clk_sys_i(clk), .rstn_i(rstn),
        .clk_en_i(en), .psel_i(psel), .penable_i(pen), .pwrite_i(pw),
        .paddr_i(pa), .pwdata_i(pd), .pstrb_i(ps), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .seg_select_i(seg),
        .pin_in_i(pin), .pin_out_o(po), .pin_oe_o(poe), .pin_pu_o(ppu),
        .pin_pd_o(ppd));
    gpf_pad u_pad (.out_i(po), .oe_i(poe), .pu_i(ppu), .pd_i(ppd),
        .ext_i(ext), .ext_en_i(een), .lvl_o(pin));
    // Hang guard, far above the roughly 1130 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        repeat (16) x = x[0] ? (x >> 1) ^ 32'h8020_0003 : x >> 1;
        return x;
    endfunction
    // Expected {driven level, oe, pull-up, pull-down}
    function automatic logic [31:0] exp_pins(logic [7:0] d, lo, hi, v, s);
        logic [7:0] oe;
        oe = ~s & ~d & ((hi & lo) | (~hi & lo & v) | (hi & ~lo & ~v));
        return {oe & v, oe, ~s & d & hi & ~lo, ~s & d & ~hi & lo};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready, read data kept in rd
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge clk);
        psel <= 1;
        pw <= w;
        pa <= a;
        pd <= d;
        ps <= s;
        @(posedge clk);
        pen <= 1;
        // Wait ends once prdy is high; the hang guard ends a stuck wait
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        psel <= 0;
        pen <= 0;
    endtask
    // Reset, then quiet pins and zero registers, unmapped byte too
    task rst_chk;
        rstn <= 0;
        repeat (2) @(posedge clk);
        rstn <= 1;
        @(negedge clk);
        chk({po & poe, poe, ppu, ppd}, 0);
        for (int a = 0; a < 5; a++) begin
            apb(0, `GPF_ADDR_LEVEL + 16'(a), 0, 0);
            chk(rd, 0);
        end
        $display("test reset done");
    endtask
    task tally_and_finish;
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        rst_chk();
        for (int i = 0; i < 40; i++) begin
            q = lfsr(rs);
            rs = (i == 0) ? 32'h5ac3_3cff : lfsr(q); // First: all inputs
            seg <= q[7:0] & q[15:8];
            ext <= q[23:16];
            een <= q[31:24] & rs[7:0];
            apb(1, `GPF_ADDR_LEVEL, {24'h0, rs[31:24]}, 4'h1);
            apb(1, `GPF_ADDR_DIR, {24'h0, rs[7:0]}, 4'h1);
            if (i[0]) apb(1, `GPF_ADDR_SEL_LO, {16'h0, rs[23:8]}, 4'h3);
            else begin
                apb(1, `GPF_ADDR_SEL_LO, {24'h0, rs[15:8]}, 4'h1);
                apb(1, `GPF_ADDR_SEL_HI, {24'h0, rs[23:16]}, 4'h1);
            end
            @(posedge clk);
            en <= 0;
            repeat (2) @(posedge clk);
            en <= 1;
            repeat (2) @(posedge clk);
            @(negedge clk);
            e = exp_pins(rs[7:0], rs[15:8], rs[23:16], rs[31:24], seg);
            chk({po & poe, poe, ppu, ppd}, e);
            apb(0, `GPF_ADDR_LEVEL, 0, 0);
            chk(rd, {24'h0, (rs[7:0] & ((een & ext) | (~een & (e[15:8]
                | (~e[7:0] & ~ext))))) | (~rs[7:0] & rs[31:24])});
            apb(0, `GPF_ADDR_SEL_LO, 0, 0);
            chk(rd, {16'h0, rs[23:8]});
            apb(0, `GPF_ADDR_SEL_HI, 0, 0);
            chk(rd, {24'h0, rs[23:16]});
            apb(0, `GPF_ADDR_DIR, 0, 0);
            chk(rd, {24'h0, rs[7:0]});
        end
        $display("test random done");
        rst_chk();
        tally_and_finish();
    end
endmodule
bind gpf_port gpf_checker #(.NPINS(NPINS)) u_chk (.clk_sys_i, .rstn_i,
    .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .seg_select_i,
    .pin_oe_o, .pin_pu_o, .pin_pd_o);
